// >>> core/dsi_pkg.sv
package dsi_pkg;
   // ---------------------------------------------------------------
   // Register map of the controller (AXI4-Lite byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_IRQ_STAT = 8'h08;
   localparam logic [7:0] A_IRQ_MASK = 8'h0C;
   localparam int CTRL_START = 0;
   localparam int CTRL_SKIP = 1;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_FAIL = 1;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // Converter serial-port map and start-up values
   // ---------------------------------------------------------------
   localparam logic [7:0] D_SPORT_CFG = 8'h00;
   localparam logic [7:0] D_CLK_CM_A = 8'h22;
   localparam logic [7:0] D_CLK_CM_B = 8'h23;
   localparam logic [7:0] D_PHC_CFG_A = 8'h24;
   localparam logic [7:0] D_PHC_CFG_B = 8'h25;
   localparam logic [7:0] D_PHC_RUN = 8'h26;
   localparam logic [7:0] D_PHC_LOCK = 8'h2A;
   localparam logic [7:0] V_SPORT_MSB4 = 8'h00;
   localparam logic [7:0] V_SOFT_RESET = 8'h20;
   localparam logic [7:0] V_CLK_CM = 8'h0F;
   localparam logic [7:0] V_PHC_A = 8'h30;
   localparam logic [7:0] V_PHC_B = 8'h80;
   localparam logic [7:0] V_PHC_TRACK = 8'h03;
   localparam logic [7:0] V_LOCKED = 8'h01;
   // ---------------------------------------------------------------
   // Sequence steps, attempts and timing
   // ---------------------------------------------------------------
   localparam logic [3:0] ST_FIRST = 4'h0;
   localparam logic [3:0] ST_RESET = 4'h1;
   localparam logic [3:0] ST_CLK_CM = 4'h3;
   localparam logic [3:0] ST_PHC_CFG = 4'h5;
   localparam logic [3:0] ST_TRACK = 4'h7;
   localparam logic [3:0] ST_READ = 4'h8;
   localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
   localparam int LOCK_WAIT_PERIODS = 163840;
   localparam logic [3:0] DATA_CLK_DIV = 4'h4;
   localparam logic [3:0] SPI_HALF = 4'h4;
   localparam logic [4:0] SPI_BITS = 5'h18;

   typedef struct packed {
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } dsi_spi_req_t;
endpackage : dsi_pkg

// >>> core/dsi_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module dsi_spi_master (
   input wire logic aclk,
   input wire logic aresetn,
   input wire dsi_pkg::dsi_spi_req_t req,
   input wire logic start,
   output logic ready,
   output logic done,
   output logic [7:0] rdata,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   import dsi_pkg::*;

   typedef enum logic [1:0] {SP_IDLE, SP_LOW, SP_HIGH, SP_END} dsi_sp_t;
   dsi_sp_t st_reg, st_next;
   logic [23:0] sh_reg, sh_next;
   logic [7:0] rx_reg, rx_next, rdata_next;
   logic [3:0] div_reg, div_next;
   logic [4:0] bit_reg, bit_next;
   logic sclk_next, cs_n_next, mosi_next, done_next;

   assign ready = (st_reg == SP_IDLE);

   // Mode 0: data moves on the falling edge and is sampled on the rising
   // one; a read sends the same 24-bit frame and keeps the last 8 bits.
   always_comb begin
      st_next = st_reg;
      sh_next = sh_reg;
      rx_next = rx_reg;
      div_next = div_reg;
      bit_next = bit_reg;
      sclk_next = spi_sclk;
      cs_n_next = spi_cs_n;
      mosi_next = spi_mosi;
      rdata_next = rdata;
      done_next = 1'b0;
      case (st_reg)
         SP_IDLE: begin
            if (start) begin
               sh_next = {req.rd, 2'h0, 5'h00, req.addr, req.data};
               mosi_next = req.rd;
               cs_n_next = 1'b0;
               div_next = 4'h0;
               bit_next = 5'h00;
               st_next = SP_LOW;
            end
         end
         SP_LOW: begin
            if (div_reg == SPI_HALF - 4'h1) begin
               div_next = 4'h0;
               sclk_next = 1'b1;
               rx_next = {rx_reg[6:0], spi_miso};
               st_next = SP_HIGH;
            end else begin
               div_next = div_reg + 4'h1;
            end
         end
         SP_HIGH: begin
            if (div_reg == SPI_HALF - 4'h1) begin
               div_next = 4'h0;
               sclk_next = 1'b0;
               if (bit_reg == SPI_BITS - 5'h01) begin
                  st_next = SP_END;
               end else begin
                  bit_next = bit_reg + 5'h01;
                  sh_next = {sh_reg[22:0], 1'b0};
                  mosi_next = sh_reg[22];
                  st_next = SP_LOW;
               end
            end else begin
               div_next = div_reg + 4'h1;
            end
         end
         SP_END: begin
            cs_n_next = 1'b1;
            mosi_next = 1'b0;
            rdata_next = rx_reg;
            done_next = 1'b1;
            st_next = SP_IDLE;
         end
         default: st_next = SP_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= SP_IDLE;
         sh_reg <= 24'h000000;
         rx_reg <= 8'h00;
         div_reg <= 4'h0;
         bit_reg <= 5'h00;
         spi_sclk <= 1'b0;
         spi_cs_n <= 1'b1;
         spi_mosi <= 1'b0;
         rdata <= 8'h00;
         done <= 1'b0;
      end else begin
         st_reg <= st_next;
         sh_reg <= sh_next;
         rx_reg <= rx_next;
         div_reg <= div_next;
         bit_reg <= bit_next;
         spi_sclk <= sclk_next;
         spi_cs_n <= cs_n_next;
         spi_mosi <= mosi_next;
         rdata <= rdata_next;
         done <= done_next;
      end
   end
endmodule : dsi_spi_master
`default_nettype wire

// >>> core/dsi_init_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module dsi_init_sequencer #(
   parameter int LOCK_WAIT = dsi_pkg::LOCK_WAIT_PERIODS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   import dsi_pkg::*;

   // ---------------------------------------------------------------
   // Register slave
   // ---------------------------------------------------------------
   logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next, rdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic bvalid_next, rvalid_next;
   logic [1:0] bresp_next, rresp_next;
   logic skip_reg, skip_next;
   logic [1:0] mask_reg, mask_next, istat_reg, istat_next;
   logic wr_en, start_pulse, lock_evt, fail_evt;
   logic busy_reg, locked_reg, failed_reg;
   logic [1:0] att_reg;
   logic [7:0] rb_reg;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == A_CTRL) || (a == A_STATUS) ||
               (a == A_IRQ_STAT) || (a == A_IRQ_MASK);
   endfunction : mapped

   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_en = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign start_pulse = wr_en && wstrb_reg[0] && awaddr_reg == A_CTRL &&
                        wdata_reg[CTRL_START] && !busy_reg;
   assign irq = |(istat_reg & mask_reg);

   always_comb begin
      aw_have_next = aw_have_reg;
      w_have_next = w_have_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = s_axi_bvalid && !s_axi_bready;
      bresp_next = s_axi_bresp;
      rvalid_next = s_axi_rvalid && !s_axi_rready;
      rresp_next = s_axi_rresp;
      rdata_next = s_axi_rdata;
      skip_next = skip_reg;
      mask_next = mask_reg;
      istat_next = istat_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_next = 1'b1;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      if (wr_en) begin
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
         if (wstrb_reg[0]) begin
            case (awaddr_reg)
               A_CTRL: skip_next = wdata_reg[CTRL_SKIP];
               A_IRQ_STAT: istat_next = istat_reg & ~wdata_reg[1:0];
               A_IRQ_MASK: mask_next = wdata_reg[1:0];
               default: ;
            endcase
         end
      end
      // A lock or fail event in the clearing cycle still sets its bit.
      istat_next[IRQ_LOCK] = istat_next[IRQ_LOCK] | lock_evt;
      istat_next[IRQ_FAIL] = istat_next[IRQ_FAIL] | fail_evt;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            A_CTRL: rdata_next = {30'h0, skip_reg, 1'b0};
            A_STATUS: rdata_next = {16'h0, rb_reg, 2'h0, att_reg,
                                    1'b0, failed_reg, locked_reg, busy_reg};
            A_IRQ_STAT: rdata_next = {30'h0, istat_reg};
            A_IRQ_MASK: rdata_next = {30'h0, mask_reg};
            default: rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h0;
         skip_reg <= 1'b0;
         mask_reg <= MASK_RESET;
         istat_reg <= 2'h0;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         s_axi_bvalid <= bvalid_next;
         s_axi_bresp <= bresp_next;
         s_axi_rvalid <= rvalid_next;
         s_axi_rresp <= rresp_next;
         s_axi_rdata <= rdata_next;
         skip_reg <= skip_next;
         mask_reg <= mask_next;
         istat_reg <= istat_next;
      end
   end

   // ---------------------------------------------------------------
   // Start-up sequencer
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_XFER, SQ_WAIT} dsi_sq_t;
   dsi_sq_t sq_reg, sq_next;
   logic [3:0] step_reg, step_next, div_reg, div_next;
   logic [17:0] wait_reg, wait_next;
   logic [1:0] att_next;
   logic [7:0] rb_next;
   logic busy_next, locked_next, failed_next, tick;
   logic spi_start, spi_ready, spi_done;
   logic [7:0] spi_rdata;
   dsi_spi_req_t req;

   // Only the clock common-mode and the phase controller are brought up; the data receiver and the
   // alignment controller are left to software once lock is reported.
   function automatic dsi_spi_req_t step_req(input logic [3:0] s);
      case (s)
         4'h0: step_req = '{1'b0, D_SPORT_CFG, V_SPORT_MSB4};
         4'h1: step_req = '{1'b0, D_SPORT_CFG, V_SOFT_RESET};
         4'h2: step_req = '{1'b0, D_SPORT_CFG, V_SPORT_MSB4};
         4'h3: step_req = '{1'b0, D_CLK_CM_A, V_CLK_CM};
         4'h4: step_req = '{1'b0, D_CLK_CM_B, V_CLK_CM};
         4'h5: step_req = '{1'b0, D_PHC_CFG_A, V_PHC_A};
         4'h6: step_req = '{1'b0, D_PHC_CFG_B, V_PHC_B};
         4'h7: step_req = '{1'b0, D_PHC_RUN, V_PHC_TRACK};
         default: step_req = '{1'b1, D_PHC_LOCK, 8'h00};
      endcase
   endfunction : step_req

   assign req = step_req(step_reg);
   assign spi_start = (sq_reg == SQ_ISSUE) && spi_ready;
   assign tick = (div_reg == DATA_CLK_DIV - 4'h1);
   assign div_next = tick ? 4'h0 : div_reg + 4'h1;

   always_comb begin
      sq_next = sq_reg;
      step_next = step_reg;
      wait_next = wait_reg;
      att_next = att_reg;
      rb_next = rb_reg;
      busy_next = busy_reg;
      locked_next = locked_reg;
      failed_next = failed_reg;
      lock_evt = 1'b0;
      fail_evt = 1'b0;
      case (sq_reg)
         SQ_IDLE: begin
            if (start_pulse) begin
               step_next = ST_FIRST;
               att_next = 2'h1;
               busy_next = 1'b1;
               locked_next = 1'b0;
               failed_next = 1'b0;
               sq_next = SQ_ISSUE;
            end
         end
         SQ_ISSUE: if (spi_ready) sq_next = SQ_XFER;
         SQ_XFER: begin
            if (spi_done) begin
               sq_next = SQ_ISSUE;
               if (step_reg == ST_READ) begin
                  rb_next = spi_rdata;
                  if (spi_rdata == V_LOCKED) begin
                     locked_next = 1'b1;
                     busy_next = 1'b0;
                     lock_evt = 1'b1;
                     sq_next = SQ_IDLE;
                  end else if (att_reg == MAX_ATTEMPTS) begin
                     failed_next = 1'b1;
                     busy_next = 1'b0;
                     fail_evt = 1'b1;
                     sq_next = SQ_IDLE;
                  end else begin
                     att_next = att_reg + 2'h1;
                     step_next = ST_PHC_CFG;
                  end
               end else if (step_reg == ST_TRACK) begin
                  wait_next = 18'h0;
                  sq_next = SQ_WAIT;
               end else if (step_reg == ST_FIRST && skip_reg) begin
                  step_next = ST_CLK_CM;
               end else begin
                  step_next = step_reg + 4'h1;
               end
            end
         end
         SQ_WAIT: begin
            if (tick) begin
               // One extra tick covers the partial first data period.
               if (wait_reg == 18'(LOCK_WAIT)) begin
                  step_next = ST_READ;
                  sq_next = SQ_ISSUE;
               end else begin
                  wait_next = wait_reg + 18'h1;
               end
            end
         end
         default: sq_next = SQ_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sq_reg <= SQ_IDLE;
         step_reg <= 4'h0;
         div_reg <= 4'h0;
         wait_reg <= 18'h0;
         att_reg <= 2'h0;
         rb_reg <= 8'h00;
         busy_reg <= 1'b0;
         locked_reg <= 1'b0;
         failed_reg <= 1'b0;
      end else begin
         sq_reg <= sq_next;
         step_reg <= step_next;
         div_reg <= div_next;
         wait_reg <= wait_next;
         att_reg <= att_next;
         rb_reg <= rb_next;
         busy_reg <= busy_next;
         locked_reg <= locked_next;
         failed_reg <= failed_next;
      end
   end

   dsi_spi_master u_spi (
      .aclk(aclk),
      .aresetn(aresetn),
      .req(req),
      .start(spi_start),
      .ready(spi_ready),
      .done(spi_done),
      .rdata(spi_rdata),
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi),
      .spi_miso(spi_miso)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   dsi_spi_req_t last_reg;
   logic [17:0] since_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_reg <= '0;
         since_reg <= 18'h0;
      end else begin
         if (spi_start) last_reg <= req;
         if (spi_start && req.addr == D_PHC_RUN) since_reg <= 18'h0;
         else if (tick && since_reg != 18'h3FFFF) since_reg <= since_reg + 18'h1;
      end
   end
   a_first_write_cfg: assert property ($rose(busy_reg) |->
      (spi_start && req == '{1'b0, D_SPORT_CFG, V_SPORT_MSB4}))
      else $error("first write is not 0x00 to 0x00");
   a_reset_then_clear: assert property (spi_start &&
      last_reg.data == V_SOFT_RESET && last_reg.addr == D_SPORT_CFG |->
      req.addr == D_SPORT_CFG && req.data == V_SPORT_MSB4)
      else $error("soft reset not cleared next");
   a_skip_reset: assert property (spi_start && skip_reg |->
      req.data != V_SOFT_RESET)
      else $error("soft reset issued while skipped");
   a_cm_pair: assert property (spi_start && req.addr == D_CLK_CM_B |->
      last_reg == '{1'b0, D_CLK_CM_A, V_CLK_CM})
      else $error("common-mode writes out of order");
   a_phase_cfg: assert property (spi_start && req.addr == D_PHC_CFG_B |->
      req.data == V_PHC_B && last_reg == '{1'b0, D_PHC_CFG_A, V_PHC_A})
      else $error("phase controller config wrong");
   a_lock_wait: assert property (spi_start && req.rd |->
      since_reg >= 18'(LOCK_WAIT) - 18'h1)
      else $error("lock read before the wait ended");
   a_attempt_limit: assert property (fail_evt |->
      att_reg == MAX_ATTEMPTS && rb_next != V_LOCKED)
      else $error("failure not after three attempts");
   a_lock_report: assert property (lock_evt |=>
      istat_reg[IRQ_LOCK] && locked_reg && !busy_reg)
      else $error("lock not reported");
   a_one_at_time: assert property (spi_start |=>
      !spi_start [*8])
      else $error("overlapping serial transactions");
   c_lock_first: cover property (lock_evt && att_reg == 2'h1);
   c_lock_fail: cover property (fail_evt);
   c_lock_retry: cover property (lock_evt && att_reg == 2'h2);
   c_skip_run: cover property (start_pulse && skip_reg);
endmodule : dsi_init_sequencer
`default_nettype wire

// >>> verification/dsi_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsi_dev_model #(
   parameter logic [7:0] DEF = 8'h00
) (
   input wire logic aclk,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   input wire logic [1:0] fails,
   output logic [23:0] frame_o,
   output logic [4:0] cnt_o
);
   logic [7:0] rg [0:63];
   logic [7:0] rdv;
   logic rdf;
   int nrd;
   initial begin
      spi_miso = 1'b0;
      frame_o = 24'h000000;
      cnt_o = 5'h00;
      rdf = 1'b0;
      nrd = 0;
      foreach (rg[i]) rg[i] = DEF;
   end
   // A released data line toggles, so a stale bit never passes for data.
   always @(posedge aclk) if (spi_cs_n) spi_miso <= ~spi_miso;
   always @(negedge spi_cs_n) begin
      cnt_o = 5'h00;
      rdf = 1'b0;
   end
   always @(posedge spi_sclk) if (!spi_cs_n) begin
      frame_o = {frame_o[22:0], spi_mosi};
      cnt_o = cnt_o + 5'h01;
      if (cnt_o == 5'h10 && frame_o[15]) begin
         rdf = 1'b1;
         if (frame_o[7:0] != 8'h2A) rdv = rg[frame_o[5:0]];
         else if (nrd < fails) rdv = 8'h03;
         else rdv = 8'h01;
         if (frame_o[7:0] == 8'h2A) nrd++;
      end
      if (cnt_o == 5'h18 && !frame_o[23]) begin
         if (frame_o[15:0] == 16'h0020) foreach (rg[i]) rg[i] = DEF;
         else rg[frame_o[13:8]] = frame_o[7:0];
         if (frame_o[15:8] == 8'h22) nrd = 0;
      end
   end
   always @(negedge spi_sclk) if (!spi_cs_n)
      spi_miso <= (rdf && cnt_o < 5'h18) ? rdv[3'(5'h17 - cnt_o)] : ~spi_miso;
endmodule : dsi_dev_model
`default_nettype wire

// >>> verification/tb_dsi_init_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dsi_init_sequencer;
   import dsi_pkg::*;
   localparam int LW = 8;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [1:0] fails = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic sclk, cs_n, mosi, miso;
   logic [23:0] frame;
   logic [4:0] cnt;
   logic [23:0] lastf = 24'h0;
   logic [23:0] got[$];
   logic [23:0] ex[$];
   int num_errors = 0;
   int checked = 0;
   int seed = 32'ha6e2;
   int tick = 0;
   int t_end = 0;
   dsi_init_sequencer #(.LOCK_WAIT(LW)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(irq), .spi_sclk(sclk), .spi_cs_n(cs_n),
      .spi_mosi(mosi), .spi_miso(miso));
   dsi_dev_model dev (.aclk(aclk), .spi_sclk(sclk), .spi_cs_n(cs_n),
      .spi_mosi(mosi), .spi_miso(miso), .fails(fails), .frame_o(frame),
      .cnt_o(cnt));
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) tick <= tick + 1;
   always @(posedge cs_n) if (cnt === 5'h18) begin
      got.push_back(frame);
      lastf = frame;
      t_end = tick;
   end
   always @(negedge cs_n) if (lastf === 24'h002603)
      chk("wait", 32'(tick - t_end >= LW * 4 && tick - t_end <= LW * 4 + 16),
         32'h1);
   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic summarize;
      if (num_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      bit aw;
      bit w;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      forever begin
         @(posedge aclk);
         if (aw && w && bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
         if (!aw && awready === 1'b1) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      bit ar;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ar = 1'b0;
      forever begin
         @(posedge aclk);
         if (ar && rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
         if (!ar && arready === 1'b1) begin
            ar = 1'b1;
            arvalid <= 1'b0;
         end
      end
   endtask : axr
   task automatic run(input logic sk, input logic [1:0] f,
      input logic [1:0] m);
      logic [1:0] r;
      logic [31:0] d;
      logic lk;
      logic [1:0] at;
      fails <= f;
      axw(A_IRQ_MASK, {30'h0, m}, r);
      axw(A_CTRL, {30'h0, sk, 1'b0}, r);
      axr(A_CTRL, d, r);
      chk("ctrl", d, {30'h0, sk, 1'b0});
      got.delete();
      axw(A_CTRL, {30'h0, sk, 1'b1}, r);
      // A second start lands while busy and must not add frames.
      axw(A_CTRL, {30'h0, sk, 1'b1}, r);
      lk = (f != 2'h3);
      at = lk ? f + 2'h1 : 2'h3;
      ex = {24'h000000};
      if (!sk) ex = {ex, 24'h000020, 24'h000000};
      ex = {ex, 24'h00220F, 24'h00230F};
      for (int k = 0; k < int'(at); k++)
         ex = {ex, 24'h002430, 24'h002580, 24'h002603, 24'h802A00};
      do axr(A_STATUS, d, r); while (d[0] !== 1'b0);
      chk("count", got.size(), ex.size());
      foreach (ex[i]) chk("frame", got[i] & (ex[i][23] ? 24'hFFFF00 :
         24'hFFFFFF), ex[i]);
      chk("status", d, {16'h0, lk ? 8'h01 : 8'h03, 2'h0, at, 1'b0, !lk, lk,
         1'b0});
      chk("irq", irq, |({!lk, lk} & m));
      axr(A_IRQ_STAT, d, r);
      chk("istat", d, {30'h0, !lk, lk});
      axw(A_IRQ_STAT, 32'h3, r);
      axr(A_IRQ_STAT, d, r);
      chk("iclr", {d[1:0], irq}, 3'h0);
   endtask : run
   initial begin
      logic [1:0] r;
      logic [31:0] d;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         axr(8'(k * 4), d, r);
         chk("reset", d, 32'h0);
         chk("resp", r, RESP_OKAY);
      end
      chk("irq0", irq, 1'b0);
      axw(8'h10, 32'h3, r);
      chk("unmw", r, RESP_SLVERR);
      axr(8'h14, d, r);
      chk("unmr", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
      wstrb <= 4'h0;
      axw(A_CTRL, 32'h1, r);
      wstrb <= 4'hF;
      axr(A_STATUS, d, r);
      chk("nostrb", {d[0], 31'(got.size())}, 32'h0);
      run(1'b0, 2'h0, 2'h3);
      run(1'b1, 2'h2, 2'h0);
      run(1'b0, 2'h3, 2'h2);
      repeat (3) run(1'($random(seed)), 2'($random(seed)), 2'($random(seed)));
      summarize();
   end
   initial begin
      repeat (90000) @(posedge aclk);
      num_errors++;
      summarize();
   end
endmodule : tb_dsi_init_sequencer
`default_nettype wire
